//--- common/fci_defines.svh
// Register map, command bytes, operation codes and timing counts of the flash host
`ifndef FCI_DEFINES_SVH
`define FCI_DEFINES_SVH

// Register byte offsets on the software port
`define FCI_REG_CTRL 8'h00
`define FCI_REG_ADDR 8'h04
`define FCI_REG_DATA 8'h08
`define FCI_REG_OP 8'h0C
`define FCI_REG_STAT 8'h10
`define FCI_REG_RDATA 8'h14

// Control register fields
`define FCI_CTRL_SUPPLY 0
`define FCI_CTRL_BYTE 1

// Status register fields
`define FCI_STAT_BUSY 0
`define FCI_STAT_MODE_LO 1
`define FCI_STAT_MODE_HI 2
`define FCI_STAT_BUF_OPEN 3
`define FCI_STAT_ERR_LO 8
`define FCI_STAT_ERR_HI 13
`define FCI_STAT_REM_LO 16
`define FCI_STAT_REM_HI 21

// Error bits inside the error field
`define FCI_ERR_BUSY 0
`define FCI_ERR_OP 1
`define FCI_ERR_SUPPLY 2
`define FCI_ERR_SEQ 3
`define FCI_ERR_COUNT 4
`define FCI_ERR_BUF 5

// Operation codes written to the operation register
`define FCI_OP_READ_ARRAY 4'h0
`define FCI_OP_READ_ID 4'h1
`define FCI_OP_READ_QUERY 4'h2
`define FCI_OP_READ_STATUS 4'h3
`define FCI_OP_CLEAR_STATUS 4'h4
`define FCI_OP_PROGRAM 4'h5
`define FCI_OP_ERASE 4'h6
`define FCI_OP_SUSPEND 4'h7
`define FCI_OP_RESUME 4'h8
`define FCI_OP_CONFIG 4'h9
`define FCI_OP_LOCK_SET 4'hA
`define FCI_OP_LOCK_CLEAR 4'hB
`define FCI_OP_PROTECT 4'hC
`define FCI_OP_BUF_START 4'hD
`define FCI_OP_BUF_DATA 4'hE
`define FCI_OP_READ 4'hF

// Command bytes sent to the flash
`define FCI_CMD_READ_ARRAY 8'hFF
`define FCI_CMD_READ_ID 8'h90
`define FCI_CMD_READ_QUERY 8'h98
`define FCI_CMD_READ_STATUS 8'h70
`define FCI_CMD_CLEAR_STATUS 8'h50
`define FCI_CMD_BUF_PROGRAM 8'hE8
`define FCI_CMD_PROGRAM 8'h40
`define FCI_CMD_ERASE 8'h20
`define FCI_CMD_CONFIRM 8'hD0
`define FCI_CMD_SUSPEND 8'hB0
`define FCI_CMD_CONFIG 8'hB8
`define FCI_CMD_LOCK 8'h60
`define FCI_CMD_LOCK_SET 8'h01
`define FCI_CMD_PROTECT 8'hC0

// Ready bit of the status and extended status words
`define FCI_READY_BIT 7
// Largest buffer count argument
`define FCI_BUF_MAX_BYTE 8'h1F
`define FCI_BUF_MAX_WORD 8'h0F

// Timing, in ns, and derived cycle counts
`define FCI_CLK_PERIOD_NS 50
`define FCI_WE_LOW_NS 100
`define FCI_READ_ACCESS_NS 200
`define FCI_RESET_LOW_NS 1000
`define FCI_RESET_WAKE_NS 1000
`define FCI_CYC(ns) (((ns) + `FCI_CLK_PERIOD_NS - 1) / `FCI_CLK_PERIOD_NS)
`define FCI_WE_LOW_CYC `FCI_CYC(`FCI_WE_LOW_NS)
`define FCI_READ_CYC `FCI_CYC(`FCI_READ_ACCESS_NS)
`define FCI_RESET_LOW_CYC `FCI_CYC(`FCI_RESET_LOW_NS)
`define FCI_RESET_WAKE_CYC `FCI_CYC(`FCI_RESET_WAKE_NS)
// Two cycles of input synchroniser lag added to every read
`define FCI_SYNC_LAG 2

`endif

//--- common/fci_pkg.sv
// Types shared by the flash host modules
package fci_pkg;
  typedef enum logic [1:0] {
    FCI_MODE_ARRAY,
    FCI_MODE_ID,
    FCI_MODE_QUERY,
    FCI_MODE_STATUS
  } fci_mode_t;

  typedef enum logic [1:0] {
    FCI_CYC_IDLE,
    FCI_CYC_SETUP,
    FCI_CYC_STROBE,
    FCI_CYC_HOLD
  } fci_cyc_state_t;

  typedef enum logic [3:0] {
    FCI_M_IDLE,
    FCI_M_RST_LOW,
    FCI_M_RST_WAKE,
    FCI_M_FIRST,
    FCI_M_SECOND,
    FCI_M_READ,
    FCI_M_COUNT,
    FCI_M_CONFIRM
  } fci_main_state_t;
endpackage

//--- src/fci_bus_cycle.sv
// One asynchronous flash bus cycle, read or write, with pin timing
`timescale 1ns/1ns
`include "fci_defines.svh"

module fci_bus_cycle #(
  parameter int AW = 24
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  output logic [AW-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  localparam logic [7:0] WE_LEN = 8'(`FCI_WE_LOW_CYC);
  localparam logic [7:0] RD_LEN = 8'(`FCI_READ_CYC + `FCI_SYNC_LAG);

  fci_pkg::fci_cyc_state_t st;
  logic [7:0] cnt;
  logic wr;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;

  // Data bus passes two flops before it is sampled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= fci_pkg::FCI_CYC_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st)
        fci_pkg::FCI_CYC_IDLE: begin
          if (start) begin
            wr <= is_write;
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe <= is_write;
            flash_ce_n <= 1'b0;
            st <= fci_pkg::FCI_CYC_SETUP;
          end
        end
        fci_pkg::FCI_CYC_SETUP: begin
          flash_we_n <= !wr;
          flash_oe_n <= wr;
          cnt <= (wr ? WE_LEN : RD_LEN) - 8'h01;
          st <= fci_pkg::FCI_CYC_STROBE;
        end
        fci_pkg::FCI_CYC_STROBE: begin
          if (cnt == 8'h00) begin
            // Strobe rises while address and data still stand; chip enable follows later
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!wr) begin
              rdata <= dq_s2;
            end
            st <= fci_pkg::FCI_CYC_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        fci_pkg::FCI_CYC_HOLD: begin
          flash_ce_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          done <= 1'b1;
          st <= fci_pkg::FCI_CYC_IDLE;
        end
        default: begin
          st <= fci_pkg::FCI_CYC_IDLE;
        end
      endcase
    end
  end
endmodule

//--- src/fci_host.sv
// Flash host controller: software register port in, flash command sequences out
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`include "fci_defines.svh"

module fci_host #(
  parameter int AW = 24
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic busy,
  output logic [AW-1:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_byte_n,
  output logic powerdown_reset_n,
  output logic program_enable_supply
);
  localparam logic [7:0] RST_LOW_LEN = 8'(`FCI_RESET_LOW_CYC);
  localparam logic [7:0] RST_WAKE_LEN = 8'(`FCI_RESET_WAKE_CYC);

  fci_pkg::fci_main_state_t st;
  fci_pkg::fci_mode_t mode;
  logic supply_en;
  logic byte_mode;
  logic [AW-1:0] op_addr;
  logic [15:0] op_data;
  logic [3:0] op;
  logic [15:0] last_rdata;
  logic [5:0] err;
  logic [5:0] err_set;
  logic buf_open;
  logic [AW-1:0] buf_addr;
  logic [5:0] buf_rem;
  logic [7:0] tcnt;
  logic cyc_start;
  logic cyc_write;
  logic [AW-1:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic op_go;
  logic op_ok;

  // First command byte of an operation
  function automatic logic [7:0] first_code(input logic [3:0] o);
    case (o)
      `FCI_OP_READ_ARRAY: first_code = `FCI_CMD_READ_ARRAY;
      `FCI_OP_READ_ID: first_code = `FCI_CMD_READ_ID;
      `FCI_OP_READ_QUERY: first_code = `FCI_CMD_READ_QUERY;
      `FCI_OP_READ_STATUS: first_code = `FCI_CMD_READ_STATUS;
      `FCI_OP_CLEAR_STATUS: first_code = `FCI_CMD_CLEAR_STATUS;
      `FCI_OP_PROGRAM: first_code = `FCI_CMD_PROGRAM;
      `FCI_OP_ERASE: first_code = `FCI_CMD_ERASE;
      `FCI_OP_SUSPEND: first_code = `FCI_CMD_SUSPEND;
      `FCI_OP_RESUME: first_code = `FCI_CMD_CONFIRM;
      `FCI_OP_CONFIG: first_code = `FCI_CMD_CONFIG;
      `FCI_OP_LOCK_SET: first_code = `FCI_CMD_LOCK;
      `FCI_OP_LOCK_CLEAR: first_code = `FCI_CMD_LOCK;
      `FCI_OP_PROTECT: first_code = `FCI_CMD_PROTECT;
      `FCI_OP_BUF_START: first_code = `FCI_CMD_BUF_PROGRAM;
      default: first_code = `FCI_CMD_READ_ARRAY;
    endcase
  endfunction

  // Operations that alter array, locks or protection cells
  function automatic logic is_modify(input logic [3:0] o);
    is_modify = (o == `FCI_OP_PROGRAM) || (o == `FCI_OP_ERASE) ||
                (o == `FCI_OP_LOCK_SET) || (o == `FCI_OP_LOCK_CLEAR) ||
                (o == `FCI_OP_PROTECT) || (o == `FCI_OP_BUF_START) ||
                (o == `FCI_OP_BUF_DATA);
  endfunction

  function automatic logic has_second(input logic [3:0] o);
    has_second = (o == `FCI_OP_PROGRAM) || (o == `FCI_OP_ERASE) ||
                 (o == `FCI_OP_CONFIG) || (o == `FCI_OP_LOCK_SET) ||
                 (o == `FCI_OP_LOCK_CLEAR) || (o == `FCI_OP_PROTECT);
  endfunction

  // Command byte sits in the low lane; upper lane driven as zero
  function automatic logic [15:0] cmd_word(input logic [7:0] c);
    cmd_word = {8'h00, c};
  endfunction

  // Busy status: only the low ready bit is valid, so the pulled-up lanes read as zero
  function automatic logic [15:0] status_mask(input logic [15:0] d);
    status_mask = d[`FCI_READY_BIT] ? {8'h00, d[7:0]} : 16'h0000;
  endfunction

  assign busy = (st != fci_pkg::FCI_M_IDLE);
  assign op_go = reg_wr && (reg_addr == `FCI_REG_OP);
  assign flash_byte_n = !byte_mode;
  assign program_enable_supply = supply_en;

  // Acceptance check for a new operation and the buffer-ready check; the error bits they raise
  always_comb begin
    err_set = 6'h00;
    op_ok = 1'b0;
    if (op_go) begin
      if (busy) begin
        err_set[`FCI_ERR_BUSY] = 1'b1;
      end else if (reg_wdata[3:0] == `FCI_OP_READ_ARRAY) begin
        op_ok = !buf_open;
        err_set[`FCI_ERR_SEQ] = buf_open;
      end else if (reg_wdata[31:4] != 28'h0000000) begin
        err_set[`FCI_ERR_OP] = 1'b1;
      end else if (is_modify(reg_wdata[3:0]) && !supply_en) begin
        err_set[`FCI_ERR_SUPPLY] = 1'b1;
      end else if (buf_open != (reg_wdata[3:0] == `FCI_OP_BUF_DATA)) begin
        // Anything but data inside an open buffer would abort it on the flash
        err_set[`FCI_ERR_SEQ] = 1'b1;
      end else if (reg_wdata[3:0] == `FCI_OP_BUF_START &&
                   op_data[7:0] > (byte_mode ? `FCI_BUF_MAX_BYTE : `FCI_BUF_MAX_WORD)) begin
        err_set[`FCI_ERR_COUNT] = 1'b1;
      end else begin
        op_ok = 1'b1;
      end
    end
    if (st == fci_pkg::FCI_M_READ && cyc_done && op == `FCI_OP_BUF_START &&
        !cyc_rdata[`FCI_READY_BIT]) begin
      err_set[`FCI_ERR_BUF] = 1'b1;
    end
  end

  // Software writable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      supply_en <= 1'b0;
      byte_mode <= 1'b0;
      op_addr <= '0;
      op_data <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `FCI_REG_CTRL: begin
          supply_en <= reg_wdata[`FCI_CTRL_SUPPLY];
          byte_mode <= reg_wdata[`FCI_CTRL_BYTE];
        end
        `FCI_REG_ADDR: op_addr <= reg_wdata[AW-1:0];
        `FCI_REG_DATA: op_data <= reg_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky errors: write one to clear, a new error in the same cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err <= 6'h00;
    end else if (reg_wr && reg_addr == `FCI_REG_STAT) begin
      err <= (err & ~reg_wdata[`FCI_STAT_ERR_HI:`FCI_STAT_ERR_LO]) | err_set;
    end else begin
      err <= err | err_set;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FCI_REG_CTRL: reg_rdata <= {30'h00000000, byte_mode, supply_en};
        `FCI_REG_ADDR: reg_rdata <= 32'(op_addr);
        `FCI_REG_DATA: reg_rdata <= {16'h0000, op_data};
        `FCI_REG_OP: reg_rdata <= {28'h0000000, op};
        `FCI_REG_STAT: reg_rdata <= {10'h000, buf_rem, 2'h0, err, 4'h0, buf_open, mode, busy};
        `FCI_REG_RDATA: reg_rdata <= {16'h0000, last_rdata};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Sequencer: each state but idle runs one bus cycle, or times the reset pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= fci_pkg::FCI_M_RST_LOW;
      tcnt <= RST_LOW_LEN;
      op <= `FCI_OP_READ_ARRAY;
      powerdown_reset_n <= 1'b0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= '0;
      cyc_wdata <= 16'h0000;
    end else begin
      cyc_start <= 1'b0;
      case (st)
        fci_pkg::FCI_M_IDLE: begin
          if (op_ok) begin
            op <= reg_wdata[3:0];
            cyc_start <= 1'b1;
            cyc_addr <= op_addr;
            if (reg_wdata[3:0] == `FCI_OP_READ) begin
              cyc_write <= 1'b0;
              st <= fci_pkg::FCI_M_READ;
            end else if (reg_wdata[3:0] == `FCI_OP_BUF_DATA) begin
              cyc_write <= 1'b1;
              cyc_wdata <= op_data;
              st <= fci_pkg::FCI_M_SECOND;
            end else begin
              cyc_write <= 1'b1;
              cyc_wdata <= cmd_word(first_code(reg_wdata[3:0]));
              st <= fci_pkg::FCI_M_FIRST;
            end
          end
        end
        fci_pkg::FCI_M_RST_LOW: begin
          // Hold the flash in reset; it aborts work and returns to array reads
          if (tcnt <= 8'h01) begin
            powerdown_reset_n <= 1'b1;
            tcnt <= RST_WAKE_LEN;
            st <= fci_pkg::FCI_M_RST_WAKE;
          end else begin
            tcnt <= tcnt - 8'h01;
          end
        end
        fci_pkg::FCI_M_RST_WAKE: begin
          // No access until the flash has woken up
          if (tcnt <= 8'h01) begin
            st <= fci_pkg::FCI_M_IDLE;
          end else begin
            tcnt <= tcnt - 8'h01;
          end
        end
        fci_pkg::FCI_M_FIRST: begin
          if (cyc_done) begin
            if (has_second(op)) begin
              cyc_start <= 1'b1;
              cyc_write <= 1'b1;
              case (op)
                `FCI_OP_ERASE: cyc_wdata <= cmd_word(`FCI_CMD_CONFIRM);
                `FCI_OP_LOCK_SET: cyc_wdata <= cmd_word(`FCI_CMD_LOCK_SET);
                `FCI_OP_LOCK_CLEAR: cyc_wdata <= cmd_word(`FCI_CMD_CONFIRM);
                `FCI_OP_CONFIG: cyc_wdata <= cmd_word(op_data[7:0]);
                default: cyc_wdata <= op_data;
              endcase
              st <= fci_pkg::FCI_M_SECOND;
            end else if (op == `FCI_OP_READ_STATUS || op == `FCI_OP_BUF_START) begin
              cyc_start <= 1'b1;
              cyc_write <= 1'b0;
              st <= fci_pkg::FCI_M_READ;
            end else begin
              st <= fci_pkg::FCI_M_IDLE;
            end
          end
        end
        fci_pkg::FCI_M_SECOND: begin
          if (cyc_done) begin
            if (op == `FCI_OP_BUF_DATA && buf_rem == 6'h01) begin
              // Confirm goes out right after the last data word
              cyc_start <= 1'b1;
              cyc_write <= 1'b1;
              cyc_addr <= buf_addr;
              cyc_wdata <= cmd_word(`FCI_CMD_CONFIRM);
              st <= fci_pkg::FCI_M_CONFIRM;
            end else begin
              st <= fci_pkg::FCI_M_IDLE;
            end
          end
        end
        fci_pkg::FCI_M_READ: begin
          if (cyc_done) begin
            if (op == `FCI_OP_BUF_START && cyc_rdata[`FCI_READY_BIT]) begin
              cyc_start <= 1'b1;
              cyc_write <= 1'b1;
              cyc_wdata <= {8'h00, op_data[7:0]};
              st <= fci_pkg::FCI_M_COUNT;
            end else begin
              st <= fci_pkg::FCI_M_IDLE;
            end
          end
        end
        fci_pkg::FCI_M_COUNT: begin
          if (cyc_done) begin
            st <= fci_pkg::FCI_M_IDLE;
          end
        end
        fci_pkg::FCI_M_CONFIRM: begin
          if (cyc_done) begin
            st <= fci_pkg::FCI_M_IDLE;
          end
        end
        default: begin
          st <= fci_pkg::FCI_M_IDLE;
        end
      endcase
    end
  end

  // Write buffer bookkeeping
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_open <= 1'b0;
      buf_addr <= '0;
      buf_rem <= 6'h00;
    end else if (st == fci_pkg::FCI_M_COUNT && cyc_done) begin
      buf_open <= 1'b1;
      buf_addr <= op_addr;
      buf_rem <= 6'(op_data[4:0]) + 6'h01;
    end else if (st == fci_pkg::FCI_M_SECOND && cyc_done && op == `FCI_OP_BUF_DATA) begin
      buf_rem <= buf_rem - 6'h01;
    end else if (st == fci_pkg::FCI_M_CONFIRM && cyc_done) begin
      buf_open <= 1'b0;
    end
  end

  // Read mode the flash is believed to be in; last data read back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= fci_pkg::FCI_MODE_ARRAY;
      last_rdata <= 16'h0000;
    end else if (st == fci_pkg::FCI_M_RST_LOW) begin
      mode <= fci_pkg::FCI_MODE_ARRAY;
    end else if (st == fci_pkg::FCI_M_FIRST && cyc_done) begin
      case (op)
        // The flash may still ignore this while busy; software checks ready first
        `FCI_OP_READ_ARRAY: mode <= fci_pkg::FCI_MODE_ARRAY;
        `FCI_OP_READ_ID: mode <= fci_pkg::FCI_MODE_ID;
        `FCI_OP_READ_QUERY: mode <= fci_pkg::FCI_MODE_QUERY;
        default: mode <= fci_pkg::FCI_MODE_STATUS;
      endcase
    end else if (st == fci_pkg::FCI_M_READ && cyc_done) begin
      if (mode == fci_pkg::FCI_MODE_STATUS || op != `FCI_OP_READ) begin
        last_rdata <= status_mask(cyc_rdata);
      end else begin
        last_rdata <= cyc_rdata;
      end
    end
  end

  fci_bus_cycle #(
    .AW(AW)
  ) u_cycle (
    .clk(clk),
    .rstn(rstn),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );
endmodule

//--- tb/fci_flash_model.sv
// Behavioural parallel flash answering the host
`timescale 1ns/1ns
module fci_flash_model #(
  parameter int AW = 24,
  parameter logic [15:0] ID_MAKER = 16'h00A5 // Arbitrary identity value
) (
  input wire logic [AW-1:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic powerdown_reset_n,
  input wire logic flash_busy,
  output logic [15:0] flash_dq_in,
  output logic [15:0] last_wr,
  output logic [15:0] prev_wr,
  output logic [AW-1:0] last_addr,
  output int nwr
);
  logic [1:0] mode;
  logic [15:0] val;
  logic [15:0] held;
  initial begin
    mode = 2'd0;
    nwr = 0;
    held = 16'h0000;
  end
  always @(negedge powerdown_reset_n) mode <= 2'd0;
  // Capture on whichever of the two strobes ends the write first
  always @(posedge flash_we_n or posedge flash_ce_n) begin
    if (flash_we_n ^ flash_ce_n) begin
      nwr <= nwr + 1;
      prev_wr <= last_wr;
      last_wr <= flash_dq_out;
      last_addr <= flash_addr;
      case (flash_dq_out[7:0])
        8'hFF: mode <= 2'd0;
        8'h90: mode <= 2'd1;
        8'h98: mode <= 2'd2;
        8'h70, 8'hE8: mode <= 2'd3;
        default: ;
      endcase
    end
  end
  // Busy only when the bench asks; floating lanes then read as ones through the pull-ups
  always_comb begin
    case (mode)
      2'd0: val = flash_addr[15:0];
      2'd1: val = ID_MAKER;
      2'd2: val = 16'h0051;
      default: val = flash_busy ? 16'hFF7F : 16'h0080;
    endcase
  end
  always @(posedge flash_oe_n) held <= val;
  // A released bus shows the inverse of the last value, not a stale copy
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n && powerdown_reset_n) ? val : ~held;
endmodule

//--- tb/fci_host_asserts.sv
// Pin and register port protocol checks on the flash host
`timescale 1ns/1ns
module fci_host_asserts #(
  parameter int AW = 24
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic busy,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic powerdown_reset_n,
  input wire logic program_enable_supply
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
    else $error("write strobe outside select");
  chk_we_hold: assert property ($rose(flash_we_n) |-> !flash_ce_n && $stable(flash_addr)
    && $stable(flash_dq_out)) else $error("write data moved at strobe end");
  chk_we_width: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
    else $error("write strobe width");
  chk_read_float: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("host drives bus in read");
  chk_rdata_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside its slot");
  chk_wake_busy: assert property ($rose(powerdown_reset_n) |-> busy[*8])
    else $error("busy fell during wake");
  chk_supply_gate: assert property ($fell(flash_we_n) && !program_enable_supply
    |-> flash_dq_out[7:0] inside {8'hFF, 8'h90, 8'h98, 8'h70, 8'h50})
    else $error("modify command without supply");
  chk_cmd_upper: assert property ($fell(flash_we_n) && flash_dq_out[7:0] inside {8'hFF, 8'h90,
    8'h98, 8'h70, 8'h50, 8'hE8, 8'h20, 8'hB0, 8'hB8, 8'h60, 8'hC0} |-> flash_dq_out[15:8] == 8'h00)
    else $error("command upper byte not zero");
endmodule
bind fci_host fci_host_asserts #(.AW(AW)) i_chk (.clk(clk), .rstn(rstn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .busy(busy), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .powerdown_reset_n(powerdown_reset_n),
  .program_enable_supply(program_enable_supply));

//--- tb/tb_fci_host.sv
// Self-checking bench for the flash host
`timescale 1ns/1ns
`include "fci_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_fci_host;
  logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, busy, we_n, ce_n, oe_n, pd_n, dq_oe;
  logic bn, ps, fb = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d;
  logic [23:0] fa, la;
  logic [15:0] dq_o, dq_i, lw, pw;
  int n_errors = 0, tests_run = 0, cyc = 0, n0, nwr;
  fci_host i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .flash_addr(fa),
    .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq_i), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_byte_n(bn), .powerdown_reset_n(pd_n),
    .program_enable_supply(ps));
  fci_flash_model i_flash (.flash_addr(fa), .flash_dq_out(dq_o), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .powerdown_reset_n(pd_n), .flash_busy(fb),
    .flash_dq_in(dq_i),
    .last_wr(lw), .prev_wr(pw), .last_addr(la), .nwr(nwr));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait so a stuck sequence counts an error after 2000 cycles
  task automatic idle();
    repeat (2000) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) break;
    end
    if (busy !== 1'b0) n_errors++;
  endtask
  task automatic op(input logic [3:0] c);
    n0 = nwr;
    wr(`FCI_REG_OP, {28'h0, c});
    idle();
  endtask
  task automatic errs(input logic [5:0] e);
    rd(`FCI_REG_STAT);
    `CHK("errors", e, d[13:8])
    wr(`FCI_REG_STAT, 32'h3F00);
  endtask
  task automatic rst();
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    idle();
  endtask
  task automatic t_reads();
    logic [7:0] cmd [4] = '{8'hFF, 8'h90, 8'h98, 8'h70};
    logic [15:0] val [4] = '{16'h1234, 16'h00A5, 16'h0051, 16'h0080};
    wr(`FCI_REG_ADDR, 32'h1234);
    for (int i = 0; i < 4; i++) begin
      op(4'(i));
      `CHK("cmd", {8'h00, cmd[i]}, lw)
      rd(`FCI_REG_STAT);
      `CHK("mode", 2'(i), d[2:1])
      op(`FCI_OP_READ);
      rd(`FCI_REG_RDATA);
      `CHK("read", val[i], d[15:0])
    end
  endtask
  task automatic t_mods();
    logic [3:0] oc [9] = '{`FCI_OP_PROGRAM, `FCI_OP_ERASE, `FCI_OP_CONFIG, `FCI_OP_LOCK_SET,
      `FCI_OP_LOCK_CLEAR, `FCI_OP_PROTECT, `FCI_OP_CLEAR_STATUS, `FCI_OP_SUSPEND, `FCI_OP_RESUME};
    logic [7:0] c1 [9] = '{8'h40, 8'h20, 8'hB8, 8'h60, 8'h60, 8'hC0, 8'h50, 8'hB0, 8'hD0};
    logic [7:0] c2 [9] = '{8'h5A, 8'hD0, 8'h5A, 8'h01, 8'hD0, 8'h5A, 8'h50, 8'hB0, 8'hD0};
    wr(`FCI_REG_CTRL, 32'h1);
    wr(`FCI_REG_DATA, 32'hA55A);
    for (int i = 0; i < 9; i++) begin
      op(oc[i]);
      `CHK("writes", (i < 6) ? 2 : 1, nwr - n0)
      `CHK("second", c2[i], lw[7:0])
      if (i < 6) `CHK("first", {8'h00, c1[i]}, pw)
      if (i < 6) `CHK("addr", 24'h1234, la)
    end
    `CHK("supply pin", 1'b1, ps)
    wr(`FCI_REG_OP, {28'h0, `FCI_OP_ERASE});
    wr(`FCI_REG_OP, {28'h0, `FCI_OP_ERASE});
    idle();
    wr(`FCI_REG_OP, 32'h15);
    errs(6'h03);
  endtask
  task automatic t_supply();
    wr(`FCI_REG_CTRL, 32'h2);
    op(`FCI_OP_ERASE);
    `CHK("writes", 0, nwr - n0)
    `CHK("supply pin", 1'b0, ps)
    `CHK("byte pin", 1'b0, bn)
    errs(6'h04);
    op(`FCI_OP_READ_ARRAY);
    `CHK("cmd", 16'h00FF, lw)
  endtask
  task automatic t_buffer();
    wr(`FCI_REG_CTRL, 32'h1);
    fb <= 1'b1;
    wr(`FCI_REG_DATA, 32'h1);
    op(`FCI_OP_BUF_START);
    `CHK("writes", 1, nwr - n0)
    op(`FCI_OP_READ);
    rd(`FCI_REG_RDATA);
    `CHK("busy status", 32'h0, d)
    fb <= 1'b0;
    errs(6'h20);
    wr(`FCI_REG_DATA, 32'h10);
    op(`FCI_OP_BUF_START);
    `CHK("writes", 0, nwr - n0)
    op(`FCI_OP_BUF_DATA);
    errs(6'h18);
    wr(`FCI_REG_DATA, 32'h1);
    op(`FCI_OP_BUF_START);
    `CHK("setup", 16'h00E8, pw)
    `CHK("count", 8'h01, lw[7:0])
    wr(`FCI_REG_DATA, 32'hA55A);
    op(`FCI_OP_BUF_DATA);
    `CHK("data", 16'hA55A, lw)
    op(`FCI_OP_BUF_DATA);
    `CHK("writes", 2, nwr - n0)
    `CHK("confirm", 16'h00D0, lw)
    rd(`FCI_REG_STAT);
    `CHK("open", 1'b0, d[3])
  endtask
  task automatic t_reset();
    op(`FCI_OP_READ_ID);
    rst();
    wr(`FCI_REG_ADDR, 32'h1234);
    op(`FCI_OP_READ);
    rd(`FCI_REG_RDATA);
    `CHK("read", 32'h1234, d)
  endtask
  initial begin
    rst();
    t_reads();
    t_mods();
    t_supply();
    t_buffer();
    t_reset();
    print_verdict();
  end
endmodule
